// ### hw/fsc_clock_div.v
// Flash timing clock divider: optional prescale by eight, then ratio plus one
`timescale 1ns/1ps
`include "fsc_map.vh"

module fsc_clock_div
(
  input  wire       SYS_CLK,
  input  wire       RST_N,
  input  wire       run,
  input  wire       prescale,
  input  wire [5:0] ratio,
  output reg        tick
);

  reg [2:0] pre_reg;
  reg [5:0] cnt_reg;
  wire      pre_tick;

  assign pre_tick = !prescale || (pre_reg == `FSC_PRESCALE_LAST);   // R15

  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pre_reg <= 3'h0;
      cnt_reg <= 6'h00;
      tick    <= 1'b0;
    end
    else if (!run)
    begin
      pre_reg <= 3'h0;
      cnt_reg <= 6'h00;
      tick    <= 1'b0;
    end
    else
    begin
      pre_reg <= prescale ? pre_reg + 3'h1 : 3'h0;                  // R15
      tick    <= 1'b0;
      if (pre_tick)
      begin
        if (cnt_reg >= ratio)                                       // R16
        begin
          cnt_reg <= 6'h00;
          tick    <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

endmodule

// ### hw/fsc_flash_security.v
// Flash security gate, backdoor key unlock and flash clock ratio register
`timescale 1ns/1ps
`include "fsc_map.vh"

// Notes on behaviour
// R1 - Secured: unsecured-code or debug memory access blocked, writes dropped, reads zero.
// R2 - Code from secure memory always keeps full access.
// R3 - Security code 1:0 is unsecured; every other value is secure.
// R4 - Each reset copies the nonvolatile option byte into the option shadow.
// R5 - On-chip debug enable is refused while secure; unsecured debug access works.
// R6 - Permission bit zero disables the key path; only mass erase unlocks.
// R7 - Key mode set makes key-location writes comparison values, not commands.
// R8 - Software writes key bytes in ascending order, never on adjacent cycles.
// R9 - Key mode cleared after eight matching bytes sets code to 1:0.
// R10 - Only writes from secure code count as key writes.
// R11 - Protection shadow changes only through debug writes.
// R12 - Blank check of erased flash unsecures until next reset.
// R13 - Ratio bit 7 read-only; bits 6:0 take only the first write.
// R14 - First ratio write sets flag; program and erase disabled while clear.
// R15 - Prescale bit selects bus clock or bus clock divided by eight.
// R16 - Divider input divided by ratio field plus one gives timing clock.
// R17 - Software keeps flash timing clock between 150 and 200 kHz.
// R18 - Program and erase timed in whole flash timing clock pulses.
// R19 - Key mode clear: key-location writes start a program or erase command.
// R20 - Any mismatching key byte leaves security unchanged.
module fsc_flash_security
(
  input  wire        SYS_CLK,
  input  wire        RST_N,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire        PREADY,
  output reg  [31:0] PRDATA,
  output wire        PSLVERR,
  // Access source qualifiers for APB writes
  input  wire        BUS_FROM_SECURE,
  input  wire        BUS_FROM_DEBUG,
  // Nonvolatile contents sampled at reset release
  input  wire [7:0]  NV_OPTION_BYTE,
  input  wire [7:0]  NV_PROT_BYTE,
  input  wire [63:0] NV_KEY_BYTES,
  // Memory access gate
  input  wire        MEM_REQ,
  input  wire        MEM_WRITE,
  input  wire        MEM_FROM_SECURE,
  input  wire        MEM_FROM_DEBUG,
  input  wire [7:0]  MEM_RDATA_IN,
  output wire        MEM_WRITE_EN,
  output wire [7:0]  MEM_RDATA_OUT,
  // Debug module enable and blank check
  input  wire        DEBUG_ENABLE_REQ,
  output wire        DEBUG_ENABLE,
  input  wire        BLANK_CHECK_DONE,
  input  wire        BLANK_CHECK_ERASED,
  // Flash timing
  input  wire        PE_BUSY,
  output wire        FLASH_TICK,
  output wire        PE_ENABLE,
  output reg         CMD_START,
  output wire [2:0]  CMD_KEY_INDEX,
  output wire [7:0]  CMD_DATA,
  output wire        SECURE
);

  // ----------------------------------------------------------------
  // Synchronisers for the asynchronous blank check result
  // ----------------------------------------------------------------
  reg [1:0] bc_done_sync_reg;
  reg [1:0] bc_ok_sync_reg;

  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bc_done_sync_reg <= 2'h0;
      bc_ok_sync_reg   <= 2'h0;
    end
    else
    begin
      bc_done_sync_reg <= {bc_done_sync_reg[0], BLANK_CHECK_DONE};
      bc_ok_sync_reg   <= {bc_ok_sync_reg[0], BLANK_CHECK_ERASED};
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire        wr_en;
  wire        rd_en;
  wire        key_hit;
  wire [2:0]  key_idx;
  wire        mapped;
  wire        sel_ratio;
  wire        sel_config;
  wire        sel_option;
  wire        sel_prot;
  wire        sel_status;

  function is_reg_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_reg_addr = (a == off);
    end
  endfunction

  function is_key_addr;
    input [11:0] a;
    begin
      is_key_addr = (a >= `FSC_OFF_KEY_BASE) && (a <= `FSC_OFF_KEY_LAST) &&
                    (a[1:0] == 2'h0);
    end
  endfunction

  // Zero wait states: read data are registered in the setup phase,
  // so they already stand in the access phase when PREADY is sampled
  assign PREADY  = 1'b1;
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && !PENABLE && !PWRITE;
  assign key_hit = is_key_addr(PADDR);
  assign key_idx = PADDR[4:2];
  assign sel_ratio  = is_reg_addr(PADDR, `FSC_OFF_RATIO);
  assign sel_config = is_reg_addr(PADDR, `FSC_OFF_CONFIG);
  assign sel_option = is_reg_addr(PADDR, `FSC_OFF_OPTION);
  assign sel_prot   = is_reg_addr(PADDR, `FSC_OFF_PROT);
  assign sel_status = is_reg_addr(PADDR, `FSC_OFF_STATUS);
  assign mapped  = key_hit || sel_ratio || sel_config || sel_option || sel_prot || sel_status;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        loaded_reg;
  reg        ratio_written_flag_reg;
  reg        prescale_by_eight_reg;
  reg [5:0]  ratio_div_reg;
  reg        key_write_mode_reg;
  reg [7:0]  option_shadow_reg;
  reg [7:0]  protection_shadow_reg;
  reg        unlocked_reg;
  reg [7:0]  cand_reg [0:7];
  reg [7:0]  seen_reg;
  reg [7:0]  cmd_data_reg;
  reg [2:0]  cmd_idx_reg;
  reg        cmp_active_reg;
  reg [3:0]  cmp_idx_reg;
  reg        cmp_ok_reg;
  integer    i;

  wire [1:0] security_code;
  wire       secure;
  wire       backdoor_permission;
  wire [7:0] stored_byte;
  wire       key_mode_clear_wr;
  wire       cmp_last;
  wire       cmp_byte_bad;

  assign security_code = unlocked_reg ? `FSC_SEC_OPEN :
                         option_shadow_reg[`FSC_SEC_HI:`FSC_SEC_LO];
  assign secure        = (security_code != `FSC_SEC_OPEN);                 // R3
  assign backdoor_permission = option_shadow_reg[`FSC_OPT_PERMIT];
  assign SECURE        = secure;

  // Only secure code ending key mode can launch a compare
  assign key_mode_clear_wr = wr_en && sel_config && BUS_FROM_SECURE &&
                             key_write_mode_reg && !PWDATA[`FSC_CFG_KEYMODE];

  // Stored byte lags the index by one cycle, so index 8 checks byte 7
  assign cmp_last     = (cmp_idx_reg == `FSC_CMP_LAST);
  assign cmp_byte_bad = (cmp_idx_reg != 4'h0) &&
                        (stored_byte != cand_reg[cmp_idx_reg[2:0] - 3'h1]);

  fsc_key_store u_key_store
  (
    .SYS_CLK   (SYS_CLK),
    .RST_N     (RST_N),
    .load      (!loaded_reg),
    .load_data (NV_KEY_BYTES),
    .rd_idx    (cmp_idx_reg[2:0]),
    .rd_data   (stored_byte)
  );

  // ----------------------------------------------------------------
  // Reset load, ratio register, config, protection
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      loaded_reg             <= 1'b0;
      option_shadow_reg      <= `FSC_RESET_BYTE;
      protection_shadow_reg  <= `FSC_RESET_BYTE;
      ratio_written_flag_reg <= 1'b0;                                      // R14
      prescale_by_eight_reg  <= 1'b0;
      ratio_div_reg          <= 6'h00;
      key_write_mode_reg     <= 1'b0;
    end
    else
    begin
      if (!loaded_reg)
      begin
        loaded_reg            <= 1'b1;
        option_shadow_reg     <= NV_OPTION_BYTE;                           // R4
        protection_shadow_reg <= NV_PROT_BYTE;
      end
      if (wr_en && sel_ratio && !ratio_written_flag_reg)                   // R13
      begin
        ratio_written_flag_reg <= 1'b1;                                    // R14
        prescale_by_eight_reg  <= PWDATA[`FSC_RATIO_PRE];
        ratio_div_reg          <= PWDATA[`FSC_RATIO_DIV_HI:`FSC_RATIO_DIV_LO];
      end
      if (wr_en && sel_config)
        key_write_mode_reg <= PWDATA[`FSC_CFG_KEYMODE];
      if (wr_en && sel_prot && BUS_FROM_DEBUG && loaded_reg)               // R11
        protection_shadow_reg <= PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Key capture, compare and unlock
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (i = 0; i < `FSC_KEY_COUNT; i = i + 1)
        cand_reg[i] <= `FSC_RESET_BYTE;
      seen_reg       <= 8'h00;
      cmp_active_reg <= 1'b0;
      cmp_idx_reg    <= 4'h0;
      cmp_ok_reg     <= 1'b0;
      unlocked_reg   <= 1'b0;
      CMD_START      <= 1'b0;
      cmd_data_reg   <= `FSC_RESET_BYTE;
      cmd_idx_reg    <= 3'h0;
    end
    else
    begin
      CMD_START <= 1'b0;
      if (wr_en && key_hit)
      begin
        if (key_write_mode_reg)                                            // R7
        begin
          if (BUS_FROM_SECURE && !BUS_FROM_DEBUG)                          // R10
          begin
            cand_reg[key_idx] <= PWDATA[7:0];
            seen_reg[key_idx] <= 1'b1;
          end
        end
        else if (ratio_written_flag_reg)                                   // R19
        begin
          CMD_START    <= 1'b1;
          cmd_data_reg <= PWDATA[7:0];
          cmd_idx_reg  <= key_idx;
        end
      end
      if (key_mode_clear_wr)
      begin
        seen_reg <= 8'h00;
        if (backdoor_permission && (seen_reg == `FSC_KEY_ALL_SEEN))        // R6
        begin
          cmp_active_reg <= 1'b1;
          cmp_idx_reg    <= 4'h0;
          cmp_ok_reg     <= 1'b1;
        end
      end
      if (cmp_active_reg)
      begin
        cmp_idx_reg <= cmp_idx_reg + 4'h1;
        if (cmp_byte_bad)                                                  // R20
          cmp_ok_reg <= 1'b0;
        if (cmp_last)
        begin
          cmp_active_reg <= 1'b0;
          if (cmp_ok_reg && stored_byte == cand_reg[`FSC_KEY_LAST_IDX])    // R9
            unlocked_reg <= 1'b1;
        end
      end
      if (bc_done_sync_reg[1] && bc_ok_sync_reg[1])                        // R12
        unlocked_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Memory gate and debug enable
  // ----------------------------------------------------------------
  wire mem_allowed;

  assign mem_allowed   = !secure || (MEM_FROM_SECURE && !MEM_FROM_DEBUG);  // R1 R2
  assign MEM_WRITE_EN  = MEM_REQ && MEM_WRITE && mem_allowed;              // R1
  assign MEM_RDATA_OUT = (MEM_REQ && mem_allowed) ? MEM_RDATA_IN : 8'h00;  // R1
  assign DEBUG_ENABLE  = DEBUG_ENABLE_REQ && !secure;                      // R5

  // ----------------------------------------------------------------
  // Flash timing clock
  // ----------------------------------------------------------------
  assign PE_ENABLE     = ratio_written_flag_reg;                           // R14
  assign CMD_KEY_INDEX = cmd_idx_reg;
  assign CMD_DATA      = cmd_data_reg;

  fsc_clock_div u_clock_div
  (
    .SYS_CLK  (SYS_CLK),
    .RST_N    (RST_N),
    .run      (ratio_written_flag_reg && PE_BUSY),                         // R18
    .prescale (prescale_by_eight_reg),
    .ratio    (ratio_div_reg),
    .tick     (FLASH_TICK)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      PRDATA <= `FSC_RESET_WORD;
    else if (rd_en)
    begin
      PRDATA <= `FSC_RESET_WORD;
      case (PADDR)
        `FSC_OFF_RATIO:
          PRDATA[7:0] <= {ratio_written_flag_reg, prescale_by_eight_reg, ratio_div_reg};
        `FSC_OFF_CONFIG:
          PRDATA[`FSC_CFG_KEYMODE] <= key_write_mode_reg;
        `FSC_OFF_OPTION:
          PRDATA[7:0] <= {option_shadow_reg[7:2], security_code};
        `FSC_OFF_PROT:
          PRDATA[7:0] <= protection_shadow_reg;
        `FSC_OFF_STATUS:
          PRDATA[3:0] <= {CMD_START, ratio_written_flag_reg, unlocked_reg, secure};
        default:
          PRDATA <= `FSC_RESET_WORD;
      endcase
    end
  end

endmodule

// ### hw/fsc_key_store.v
// Small register memory holding the stored eight-byte backdoor key
`timescale 1ns/1ps
`include "fsc_map.vh"

module fsc_key_store
(
  input  wire       SYS_CLK,
  input  wire       RST_N,
  input  wire       load,
  input  wire [63:0] load_data,
  input  wire [2:0] rd_idx,
  output reg  [7:0] rd_data
);

  reg [7:0] mem_reg [0:7];
  integer   i;

  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (i = 0; i < `FSC_KEY_COUNT; i = i + 1)
        mem_reg[i] <= `FSC_RESET_BYTE;
      rd_data <= `FSC_RESET_BYTE;
    end
    else
    begin
      if (load)
        for (i = 0; i < `FSC_KEY_COUNT; i = i + 1)
          mem_reg[i] <= load_data[i*8 +: 8];
      rd_data <= mem_reg[rd_idx];
    end
  end

endmodule

// ### hw/fsc_map.vh
// Register offsets, field positions and reset values of the flash security block
`ifndef FSC_MAP_VH
`define FSC_MAP_VH

// APB byte offsets
`define FSC_OFF_RATIO      12'h000
`define FSC_OFF_CONFIG     12'h004
`define FSC_OFF_OPTION     12'h008
`define FSC_OFF_PROT       12'h00C
`define FSC_OFF_STATUS     12'h010
`define FSC_OFF_KEY_BASE   12'h020
`define FSC_OFF_KEY_LAST   12'h03C

// Ratio register fields
`define FSC_RATIO_FLAG     7
`define FSC_RATIO_PRE      6
`define FSC_RATIO_DIV_HI   5
`define FSC_RATIO_DIV_LO   0

// Option register fields
`define FSC_OPT_PERMIT     7
`define FSC_SEC_HI         1
`define FSC_SEC_LO         0
`define FSC_SEC_OPEN       2'h2

// Config register field
`define FSC_CFG_KEYMODE    5

// Status register fields
`define FSC_ST_SECURE      0
`define FSC_ST_UNLOCKED    1
`define FSC_ST_PE_ENABLE   2
`define FSC_ST_CMD_START   3

// Key locations, key compare end and prescaler last count
`define FSC_KEY_COUNT      8
`define FSC_KEY_LAST_IDX   3'h7
`define FSC_PRESCALE_LAST  3'h7
`define FSC_KEY_ALL_SEEN   8'hFF
`define FSC_CMP_LAST       4'h8

// Reset values
`define FSC_RESET_BYTE     8'h00
`define FSC_RESET_WORD     32'h00000000

// Flash timing limits for software, kHz
`define FSC_FCLK_MIN_KHZ   150
`define FSC_FCLK_MAX_KHZ   200

`endif

// ### tb/fsc_mem_model.sv
// Far-side model: memory array cell and blank check responder
`timescale 1ns/1ps
module fsc_mem_model
(
  input  wire       SYS_CLK,
  input  wire       MEM_REQ,
  input  wire       MEM_WRITE_EN,
  input  wire       blank_req,
  input  wire       blank_ok,
  output wire [7:0] MEM_RDATA_IN,
  output reg        BLANK_CHECK_DONE,
  output reg        BLANK_CHECK_ERASED
);
  reg [7:0] cell_reg = 8'h5A;
  initial BLANK_CHECK_DONE = 1'b0;
  initial BLANK_CHECK_ERASED = 1'b0;
  // Idle read bus shows the inverse, never a stale copy
  assign MEM_RDATA_IN = MEM_REQ ? cell_reg : ~cell_reg;
  always @(posedge SYS_CLK)
  begin
    if (MEM_WRITE_EN)
      cell_reg <= ~cell_reg;
    BLANK_CHECK_DONE <= blank_req;
    BLANK_CHECK_ERASED <= blank_req && blank_ok;
  end
endmodule

// ### tb/fsc_props.sv
// Assertion checker for the flash security block
`timescale 1ns/1ps
module fsc_props
(
  input wire        SYS_CLK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire        MEM_REQ,
  input wire        MEM_WRITE,
  input wire        MEM_FROM_SECURE,
  input wire        MEM_FROM_DEBUG,
  input wire [7:0]  MEM_RDATA_IN,
  input wire        MEM_WRITE_EN,
  input wire [7:0]  MEM_RDATA_OUT,
  input wire        DEBUG_ENABLE_REQ,
  input wire        DEBUG_ENABLE,
  input wire        FLASH_TICK,
  input wire        PE_ENABLE,
  input wire        CMD_START,
  input wire [7:0]  CMD_DATA,
  input wire        SECURE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire blk    = MEM_REQ && SECURE && (!MEM_FROM_SECURE || MEM_FROM_DEBUG);
  wire acc    = PSEL && PENABLE && PWRITE;
  wire key_wr = acc && PADDR >= 12'h020 && PADDR <= 12'h03C;
  property p_blk_wr; blk && MEM_WRITE |-> !MEM_WRITE_EN; endproperty
  a_blk_wr: assert property (p_blk_wr) else $error("blocked write passed");
  property p_blk_rd; blk && !MEM_WRITE |-> MEM_RDATA_OUT == 8'h00; endproperty
  a_blk_rd: assert property (p_blk_rd) else $error("blocked read not zero");
  property p_sec_ok;
    MEM_REQ && MEM_FROM_SECURE && !MEM_FROM_DEBUG
      |-> MEM_WRITE_EN == MEM_WRITE && (MEM_WRITE || MEM_RDATA_OUT == MEM_RDATA_IN);
  endproperty
  a_sec_ok: assert property (p_sec_ok) else $error("secure access restricted");
  property p_dbg; DEBUG_ENABLE_REQ |-> DEBUG_ENABLE == !SECURE; endproperty
  a_dbg: assert property (p_dbg) else $error("debug enable wrong");
  property p_pe_set; acc && PADDR == 12'h000 |=> PE_ENABLE; endproperty
  a_pe_set: assert property (p_pe_set) else $error("ratio write left flag clear");
  property p_pe_hold; PE_ENABLE |=> PE_ENABLE [*3]; endproperty
  a_pe_hold: assert property (p_pe_hold) else $error("ratio flag dropped");
  property p_unsec; !SECURE |=> !SECURE; endproperty
  a_unsec: assert property (p_unsec) else $error("security re-engaged");
  property p_tick; !PE_ENABLE |-> !FLASH_TICK; endproperty
  a_tick: assert property (p_tick) else $error("tick before ratio write");
  property p_cmd;
    CMD_START |-> $past(key_wr) && CMD_DATA == $past(PWDATA[7:0]);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command without key location write");
endmodule

bind fsc_flash_security fsc_props fsc_props_i (.*);

// ### tb/tb_top.sv
// Self-checking bench for the flash security block
`timescale 1ns/1ps
module tb_top;
  localparam [63:0] KEY = 64'hF00DCAFE12345678;
  reg SYS_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  reg BUS_FROM_SECURE = 1'b1, BUS_FROM_DEBUG = 1'b0, MEM_REQ = 1'b0, MEM_WRITE = 1'b0;
  reg MEM_FROM_SECURE = 1'b0, MEM_FROM_DEBUG = 1'b0, DEBUG_ENABLE_REQ = 1'b0, PE_BUSY = 1'b0;
  reg err = 1'b0, blank_req = 1'b0, blank_ok = 1'b0;
  reg  [11:0] PADDR = 12'h000;
  reg  [31:0] PWDATA = 32'h00000000, rd;
  reg  [7:0]  NV_OPTION_BYTE = 8'h83, NV_PROT_BYTE = 8'hF8;
  reg  [63:0] NV_KEY_BYTES = KEY;
  reg  [10:0] last_cmd = 11'h000;
  wire [31:0] PRDATA;
  wire [7:0]  MEM_RDATA_IN, MEM_RDATA_OUT, CMD_DATA;
  wire [2:0]  CMD_KEY_INDEX;
  wire PREADY, PSLVERR, MEM_WRITE_EN, DEBUG_ENABLE, BLANK_CHECK_DONE, BLANK_CHECK_ERASED;
  wire FLASH_TICK, PE_ENABLE, CMD_START, SECURE;
  integer n_errors = 0, checked = 0, cmd_cnt = 0, i;
  fsc_flash_security fsc_flash_security_i (.*);
  fsc_mem_model fsc_mem_model_i (.*);
  always #12.5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK)
    if (CMD_START === 1'b1)
    begin
      cmd_cnt = cmd_cnt + 1;
      last_cmd = {CMD_KEY_INDEX, CMD_DATA};
    end
  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
  begin
    checked = checked + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("unexpected %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
  begin
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  end
  endtask
  task rdc(input [11:0] a, input [31:0] e, input [8*8-1:0] nm);
  begin
    apb(a, 1'b0, 32'h00000000);
    chk(nm, e, rd);
  end
  endtask
  task mem(input s, input d, input w, input [7:0] e_rd, input e_we);
  begin
    MEM_REQ <= 1'b1;
    MEM_FROM_SECURE <= s;
    MEM_FROM_DEBUG <= d;
    MEM_WRITE <= w;
    @(posedge SYS_CLK);
    if (!w)
      chk("mem_rd", {24'h000000, e_rd}, {24'h000000, MEM_RDATA_OUT});
    chk("mem_we", {31'h0, e_we}, {31'h0, MEM_WRITE_EN});
    MEM_REQ <= 1'b0;
    @(posedge SYS_CLK);
  end
  endtask
  task key(input [63:0] k, input s, input d);
  begin
    BUS_FROM_SECURE <= s;
    BUS_FROM_DEBUG <= d;
    apb(12'h004, 1'b1, 32'h00000020);
    for (i = 0; i < 8; i = i + 1)
      apb(12'(32 + 4 * i), 1'b1, {24'h000000, k[8*i +: 8]});
    apb(12'h004, 1'b1, 32'h00000000);
    BUS_FROM_SECURE <= 1'b1;
    BUS_FROM_DEBUG <= 1'b0;
    repeat (12) @(posedge SYS_CLK);
  end
  endtask
  task tick(input [31:0] e);
    integer n;
  begin
    PE_BUSY <= 1'b1;
    n = 0;
    while (FLASH_TICK !== 1'b1 && n < 300)
    begin
      @(posedge SYS_CLK);
      n = n + 1;
    end
    @(posedge SYS_CLK);
    n = 1;
    while (FLASH_TICK !== 1'b1 && n < 300)
    begin
      @(posedge SYS_CLK);
      n = n + 1;
    end
    chk("tick", e, n);
    PE_BUSY <= 1'b0;
  end
  endtask
  task rst(input [7:0] opt);
  begin
    RST_N <= 1'b0;
    NV_OPTION_BYTE <= opt;
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
  end
  endtask
  task results;
  begin
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    rst(8'h83);
    rdc(12'h010, 32'h1, "status");
    chk("secure", 32'h1, {31'h0, SECURE});
    chk("pe_en", 32'h0, {31'h0, PE_ENABLE});
    rdc(12'h008, 32'h83, "option");
    chk("slverr", 32'h0, {31'h0, err});
    rdc(12'h00C, 32'hF8, "prot");
    mem(1'b0, 1'b0, 1'b1, 8'h00, 1'b0);
    mem(1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
    mem(1'b1, 1'b0, 1'b0, 8'h5A, 1'b0);
    mem(1'b1, 1'b0, 1'b1, 8'h00, 1'b1);
    mem(1'b1, 1'b0, 1'b0, 8'hA5, 1'b0);
    DEBUG_ENABLE_REQ <= 1'b1;
    @(posedge SYS_CLK);
    chk("dbg_en", 32'h0, {31'h0, DEBUG_ENABLE});
    $display("test gate done");
    apb(12'h00C, 1'b1, 32'h000000FF);
    rdc(12'h00C, 32'hF8, "prot");
    BUS_FROM_DEBUG <= 1'b1;
    apb(12'h00C, 1'b1, 32'h0000007E);
    BUS_FROM_DEBUG <= 1'b0;
    rdc(12'h00C, 32'h7E, "prot");
    $display("test protection done");
    rdc(12'h000, 32'h00, "ratio");
    apb(12'h000, 1'b1, 32'h00000058);
    rdc(12'h000, 32'hD8, "ratio");
    apb(12'h000, 1'b1, 32'h0000003F);
    rdc(12'h000, 32'hD8, "ratio");
    rdc(12'h010, 32'h5, "status");
    chk("pe_en", 32'h1, {31'h0, PE_ENABLE});
    tick(32'd200);
    $display("test ratio done");
    key(KEY ^ 64'h0100000000000000, 1'b1, 1'b0);
    rdc(12'h010, 32'h5, "status");
    key(KEY, 1'b0, 1'b1);
    rdc(12'h010, 32'h5, "status");
    chk("cmds", 32'h0, cmd_cnt);
    key(KEY, 1'b1, 1'b0);
    rdc(12'h010, 32'h6, "status");
    rdc(12'h008, 32'h82, "option");
    chk("secure", 32'h0, {31'h0, SECURE});
    chk("dbg_en", 32'h1, {31'h0, DEBUG_ENABLE});
    mem(1'b0, 1'b1, 1'b0, 8'hA5, 1'b0);
    $display("test key done");
    apb(12'h024, 1'b1, 32'h000000A5);
    @(posedge SYS_CLK);
    chk("cmds", 32'h1, cmd_cnt);
    chk("cmd", {21'h0, 3'h1, 8'hA5}, {21'h0, last_cmd});
    $display("test command done");
    rst(8'h03);
    rdc(12'h010, 32'h1, "status");
    apb(12'h000, 1'b1, 32'h0000003F);
    tick(32'd64);
    key(KEY, 1'b1, 1'b0);
    rdc(12'h010, 32'h5, "status");
    blank_req <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    rdc(12'h010, 32'h5, "status");
    blank_req <= 1'b0;
    @(posedge SYS_CLK);
    blank_ok <= 1'b1;
    blank_req <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    rdc(12'h010, 32'h6, "status");
    rdc(12'h100, 32'h0, "unmap");
    chk("slverr", 32'h1, {31'h0, err});
    $display("test erase unlock done");
    results;
  end
  initial
  begin
    repeat (6000) @(posedge SYS_CLK);
    n_errors = n_errors + 1;
    results;
  end
endmodule
